//--- src/tcic_map.vh
// register offsets, field positions, reset values and timing counts for the input conditioning
`ifndef TCIC_MAP_VH
`define TCIC_MAP_VH
`define TCIC_OFS_CH1 8'h24
`define TCIC_OFS_CH2 8'h28
`define TCIC_OFS_CH3 8'h2c
`define TCIC_CFG_RESET 32'h0000_0000
`define TCIC_CFG_WMASK 32'h000f_000f
`define TCIC_FLT_LSB 0
`define TCIC_FLT_MSB 3
`define TCIC_SEL_LSB 16
`define TCIC_SEL_MSB 17
`define TCIC_DIV_LSB 18
`define TCIC_DIV_MSB 19
`define TCIC_SEL_OUTPUT 2'h0
`define TCIC_SEL_OWN 2'h1
`define TCIC_SEL_PAIR 2'h2
`define TCIC_SEL_TRIG 2'h3
`define TCIC_CLK_NS 100
`endif

//--- src/tcic_input_cond.v
// input conditioning for capture channels 1 to 3: select, filter, prescale, config registers
//
// Local design decision: the plain strobed port.
`include "tcic_map.vh"

// block overview
// - three capture channels, each with its own config word
// - source pick, then N-event filter, then rising-edge prescaler
// - register port answers reads one cycle after the strobe
// - channel enables come from timer logic on this clock, no syncing
// - pins and trigger edge are asynchronous, so two flops come first
// - outputs are all registered except the direction flags
// - channel 0 pin is only a source for channel 1
// - no interrupt logic here, events go to the capture registers
// - slower sample rates are enables, never derived clocks

module tcic_input_cond (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // pins and timer-side inputs
  input wire [3:0] channel_input_i,
  input wire trigger_edge_signal_i,
  input wire counter_input_clock_en_i,
  input wire filter_base_clock_en_i,
  input wire [2:0] channel_enable_i,
  // conditioned outputs, index 0 is channel 1
  output reg [2:0] filtered_o,
  output reg [2:0] capture_event_o,
  output wire [2:0] channel_is_input_o
);

  // sample-rate selectors
  // system rate bypasses the divider entirely
  // counter input rate arrives as an enable from the timer
  // divided rates share one counter, see div_tick
  localparam [2:0] RATE_SYS = 3'h0;
  localparam [2:0] RATE_CLKIN = 3'h1;
  localparam [2:0] RATE_DIV2 = 3'h2;
  localparam [2:0] RATE_DIV4 = 3'h3;
  localparam [2:0] RATE_DIV8 = 3'h4;
  localparam [2:0] RATE_DIV16 = 3'h5;
  localparam [2:0] RATE_DIV32 = 3'h6;

  // filter code to sample rate
  function [2:0] flt_rate;
    input [3:0] code;
    begin
      case (code)
        4'h0: flt_rate = RATE_SYS;
        4'h1, 4'h2, 4'h3: flt_rate = RATE_CLKIN;
        4'h4, 4'h5: flt_rate = RATE_DIV2;
        4'h6, 4'h7: flt_rate = RATE_DIV4;
        4'h8, 4'h9: flt_rate = RATE_DIV8;
        4'ha, 4'hb, 4'hc: flt_rate = RATE_DIV16;
        default: flt_rate = RATE_DIV32;
      endcase
    end
  endfunction

  // filter code to confirming sample count N
  // count of 1 means the first differing sample switches
  // largest count is 8, so four bits hold every value
  function [3:0] flt_count;
    input [3:0] code;
    begin
      case (code)
        4'h0: flt_count = 4'h1;
        4'h1: flt_count = 4'h2;
        4'h2: flt_count = 4'h4;
        4'h3: flt_count = 4'h8;
        4'h4, 4'h6, 4'h8: flt_count = 4'h6;
        4'h5, 4'h7, 4'h9: flt_count = 4'h8;
        4'ha, 4'hd: flt_count = 4'h5;
        4'hb, 4'he: flt_count = 4'h6;
        default: flt_count = 4'h8;
      endcase
    end
  endfunction

  // register address decode, returns one-hot channel
  // any other address decodes to no channel at all
  function [2:0] reg_hit;
    input [7:0] addr;
    begin
      case (addr)
        `TCIC_OFS_CH1: reg_hit = 3'h1;
        `TCIC_OFS_CH2: reg_hit = 3'h2;
        `TCIC_OFS_CH3: reg_hit = 3'h4;
        default: reg_hit = 3'h0;
      endcase
    end
  endfunction

  // two-flop synchronisers for pins and the trigger edge
  // first stage is read only by the second stage
  // trigger edge is carried as a level, no pulse stretching
  // a trigger pulse shorter than one clock may be lost
  reg [4:0] sync_a;
  reg [4:0] sync_b;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= {trigger_edge_signal_i, channel_input_i};
      sync_b <= sync_a;
    end
  end

  // base clock divider, tick enables for /2 .. /32
  // free-running count of base clock pulses
  // each tap fires once per 2, 4, 8, 16 or 32 pulses
  // one shared counter keeps the channels' sample phases aligned
  reg [4:0] div_cnt;
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      div_cnt <= 5'h00;
    end else if (filter_base_clock_en_i) begin
      div_cnt <= div_cnt + 5'h01;
    end
  end
  // ticks are qualified by the enable so none repeat while it is low
  wire [4:0] div_tick;
  assign div_tick = {5{filter_base_clock_en_i}} &
                    {div_cnt[4:0] == 5'h1f, div_cnt[3:0] == 4'hf, div_cnt[2:0] == 3'h7,
                     div_cnt[1:0] == 2'h3, div_cnt[0]};

  // configuration registers
  // one word per channel, reserved bits never stored
  // the array is local, each channel writes only its own word
  // hit is one-hot or zero, so at most one word is touched
  // reset clears every field: output selection, no filter
  reg [31:0] cfg [0:2];
  wire [2:0] hit;
  assign hit = reg_hit(reg_addr_i);

  genvar ch;
  generate
    for (ch = 0; ch < 3; ch = ch + 1) begin : g_ch
      wire [3:0] flt_code;
      wire [1:0] sel;
      wire [1:0] div_code;
      reg raw;
      reg smp_en;
      reg [3:0] run;
      reg [3:0] evt_cnt;
      reg prev_flt;
      wire rise;
      assign flt_code = cfg[ch][`TCIC_FLT_MSB:`TCIC_FLT_LSB];
      assign sel = cfg[ch][`TCIC_SEL_MSB:`TCIC_SEL_LSB];
      assign div_code = cfg[ch][`TCIC_DIV_MSB:`TCIC_DIV_LSB];
      assign channel_is_input_o[ch] = (sel != `TCIC_SEL_OUTPUT);

      // register write, reserved bits masked off
      // selection field is locked while the channel is enabled
      // filter and prescale fields stay writable at any time
      // a locked write still updates the other fields
      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          cfg[ch] <= `TCIC_CFG_RESET;
        end else if (reg_wr_i && hit[ch]) begin
          cfg[ch][`TCIC_FLT_MSB:`TCIC_FLT_LSB] <= reg_wdata_i[`TCIC_FLT_MSB:`TCIC_FLT_LSB];
          cfg[ch][`TCIC_DIV_MSB:`TCIC_DIV_LSB] <= reg_wdata_i[`TCIC_DIV_MSB:`TCIC_DIV_LSB];
          if (!channel_enable_i[ch]) begin
            cfg[ch][`TCIC_SEL_MSB:`TCIC_SEL_LSB] <= reg_wdata_i[`TCIC_SEL_MSB:`TCIC_SEL_LSB];
          end
        end
      end

      // source selection per channel
      // channel 1 pairs with channel 0
      // channels 2 and 3 pair with each other
      // output selection drives raw low so the filter settles at zero
      // and no rising edge can reach the prescaler then
      always @* begin
        case (sel)
          `TCIC_SEL_OWN: raw = sync_b[ch + 1];
          `TCIC_SEL_PAIR: begin
            if (ch == 0) begin
              raw = sync_b[0];
            end else if (ch == 1) begin
              raw = sync_b[3];
            end else begin
              raw = sync_b[2];
            end
          end
          `TCIC_SEL_TRIG: raw = sync_b[4];
          default: raw = 1'b0;
        endcase
      end

      // sample enable from this channel's own filter code
      // another channel's code never changes this channel's rate
      always @* begin
        case (flt_rate(flt_code))
          RATE_SYS: smp_en = 1'b1;
          RATE_CLKIN: smp_en = counter_input_clock_en_i;
          RATE_DIV2: smp_en = div_tick[0];
          RATE_DIV4: smp_en = div_tick[1];
          RATE_DIV8: smp_en = div_tick[2];
          RATE_DIV16: smp_en = div_tick[3];
          default: smp_en = div_tick[4];
        endcase
      end

      // N-event filter: count samples differing from output
      // any cycle with input equal to output clears the run,
      // so a glitch between samples restarts the count
      // a changed code takes effect at the next sample
      // code 0000 switches after one differing cycle
      // run never exceeds 7, the switch happens at N
      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          run <= 4'h0;
          filtered_o[ch] <= 1'b0;
        end else if (raw == filtered_o[ch]) begin
          run <= 4'h0;
        end else if (smp_en) begin
          if (run + 4'h1 >= flt_count(flt_code)) begin
            filtered_o[ch] <= raw;
            run <= 4'h0;
          end else begin
            run <= run + 4'h1;
          end
        end
      end

      // rising-edge capture event with prescaler
      // event pulse comes one cycle after the filtered rise
      // the count is held at zero while the channel is disabled,
      // so re-enabling always starts a fresh group of events
      // the last rise of each group of 1, 2, 4 or 8 fires
      // output channels never produce events
      assign rise = filtered_o[ch] && !prev_flt && channel_is_input_o[ch];
      always @(posedge clk_i) begin
        if (sys_rst_i) begin
          prev_flt <= 1'b0;
          evt_cnt <= 4'h0;
          capture_event_o[ch] <= 1'b0;
        end else begin
          prev_flt <= filtered_o[ch];
          capture_event_o[ch] <= 1'b0;
          if (!channel_enable_i[ch]) begin
            evt_cnt <= 4'h0;
          end else if (rise) begin
            if (evt_cnt + 4'h1 >= (4'h1 << div_code)) begin
              evt_cnt <= 4'h0;
              capture_event_o[ch] <= 1'b1;
            end else begin
              evt_cnt <= evt_cnt + 4'h1;
            end
          end
        end
      end
    end
  endgenerate

  // read data, one cycle after strobe, zero elsewhere
  // zero outside the read slot lets several slaves be or-ed
  always @(posedge clk_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      case (hit)
        3'h1: reg_rdata_o <= cfg[0] & `TCIC_CFG_WMASK;
        3'h2: reg_rdata_o <= cfg[1] & `TCIC_CFG_WMASK;
        3'h4: reg_rdata_o <= cfg[2] & `TCIC_CFG_WMASK;
        default: reg_rdata_o <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_o <= 32'h0000_0000;
    end
  end

endmodule // tcic_input_cond

//--- sim/tcic_input_cond_monitor.sv
// assertion checker for the channel input conditioning ports
`include "tcic_map.vh"
module tcic_input_cond_monitor (
  // clock and reset
  input wire clk_i,
  input wire sys_rst_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  // pins and timer side
  input wire [3:0] channel_input_i,
  input wire trigger_edge_signal_i,
  input wire counter_input_clock_en_i,
  input wire filter_base_clock_en_i,
  input wire [2:0] channel_enable_i,
  // conditioned outputs
  input wire [2:0] filtered_o,
  input wire [2:0] capture_event_o,
  input wire [2:0] channel_is_input_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // register port answers
  property p_rd_idle; !$past(reg_rd_i) |-> reg_rdata_o == 32'h0000_0000; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_rsvd; $past(reg_rd_i) |-> (reg_rdata_o & ~`TCIC_CFG_WMASK) == 32'h0000_0000; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
  property p_unmapped; reg_rd_i && reg_addr_i > `TCIC_OFS_CH3 |=> reg_rdata_o == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_back; reg_wr_i && reg_addr_i == `TCIC_OFS_CH2 && !channel_enable_i[1] ##1
    reg_rd_i && reg_addr_i == `TCIC_OFS_CH2 |=> reg_rdata_o == ($past(reg_wdata_i, 2) &
    `TCIC_CFG_WMASK); endproperty
  a_rd_back: assert property (p_rd_back) else $error("read back differs");
  // selection field
  property p_sel_lock; channel_enable_i[0] && reg_wr_i && reg_addr_i == `TCIC_OFS_CH1 |=>
    $stable(channel_is_input_o[0]); endproperty
  a_sel_lock: assert property (p_sel_lock) else $error("selection changed while on");
  property p_sel_wr; !channel_enable_i[0] && reg_wr_i && reg_addr_i == `TCIC_OFS_CH1 &&
    |reg_wdata_i[17:16] |=> channel_is_input_o[0]; endproperty
  a_sel_wr: assert property (p_sel_wr) else $error("input selection not taken");
  // capture events
  property p_evt_rise; capture_event_o[0] |-> $past(filtered_o[0]) && !$past(filtered_o[0], 2);
  endproperty
  a_evt_rise: assert property (p_evt_rise) else $error("event without rise");
  property p_evt_sel; (capture_event_o & ~channel_is_input_o) == 3'h0; endproperty
  a_evt_sel: assert property (p_evt_sel) else $error("event on output channel");
  property p_en_clr; !channel_enable_i[2] [*3] |-> !capture_event_o[2]; endproperty
  a_en_clr: assert property (p_en_clr) else $error("event while disabled");
endmodule // tcic_input_cond_monitor
bind tcic_input_cond tcic_input_cond_monitor u_tcic_input_cond_monitor (.*);

//--- sim/tcic_pins_model.sv
// far-side model: capture pins, trigger controller and sampling enables
module tcic_pins_model (
  // clock and commanded levels, bit 4 is the trigger
  input wire clk_i,
  input wire [4:0] lvl_i,
  // towards the block
  output reg [3:0] pin_o = 4'h0,
  output reg trig_o = 1'b0,
  output wire cin_en_o,
  output wire base_en_o
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [1:0] cnt = 2'h0;
  // counter clock every 4th cycle, base clock every 2nd
  assign cin_en_o = (cnt == 2'h3);
  assign base_en_o = cnt[0];
  // pins follow commands one cycle late
  always @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
    pin_o <= lvl_i[3:0];
    trig_o <= lvl_i[4];
  end
endmodule // tcic_pins_model

//--- sim/tcic_input_cond_tb_top.sv
// self-checking bench for the channel input conditioning
`include "tcic_map.vh"
module tcic_input_cond_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  reg clk_i = 1'b0, sys_rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  reg [7:0] reg_addr_i = 8'h00;
  reg [31:0] reg_wdata_i = 32'h0000_0000, d;
  reg [2:0] channel_enable_i = 3'h0;
  reg [4:0] lvl = 5'h00;
  wire [31:0] reg_rdata_o;
  wire [3:0] channel_input_i;
  wire trigger_edge_signal_i, counter_input_clock_en_i, filter_base_clock_en_i;
  wire [2:0] filtered_o, capture_event_o, channel_is_input_o;
  integer seed = 32'h6ab4_3bfb, error_cnt = 0, n_compared = 0, ev = 0, c = 1, s, i, t;
  // clock, design and far side
  always #50 clk_i = ~clk_i;
  tcic_input_cond u_tcic_input_cond (.*);
  tcic_pins_model u_tcic_pins_model (.clk_i(clk_i), .lvl_i(lvl), .pin_o(channel_input_i),
    .trig_o(trigger_edge_signal_i), .cin_en_o(counter_input_clock_en_i),
    .base_en_o(filter_base_clock_en_i));
  // events of the channel under test
  always @(posedge clk_i) if (capture_event_o[c - 1] === 1'b1) ev <= ev + 1;
  task chk(input [31:0] got, input [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("unexpected at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    reg_addr_i <= a;
    reg_wdata_i <= v;
    reg_wr_i <= 1'b1;
    @(posedge clk_i) reg_wr_i <= 1'b0;
  endtask
  task rd(input [7:0] a, input [31:0] exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i) reg_rd_i <= 1'b0;
    @(negedge clk_i) chk(reg_rdata_o, exp);
    @(posedge clk_i);
  endtask
  // write a config with the channel off, then switch it on
  task cfg(input integer ch, input [31:0] v);
    channel_enable_i <= 3'h0;
    wr(8'(8'h20 + 4 * ch), v);
    channel_enable_i <= 3'h1 << (ch - 1);
  endtask
  task toggle(input [4:0] m, input integer n);
    ev = 0;
    repeat (n) begin
      lvl <= m;
      repeat (3) @(posedge clk_i);
      lvl <= 5'h00;
      repeat (3) @(posedge clk_i);
    end
    repeat (6) @(posedge clk_i);
  endtask
  // expected source pin, sample count and sample period
  function [4:0] src(input integer ch, input integer sel);
    src = sel == 3 ? 5'h10 : sel != 2 ? 5'h01 << ch : ch == 1 ? 5'h01 : ch == 2 ? 5'h08 : 5'h04;
  endfunction
  function integer nsamp(input integer f);
    nsamp = f == 0 ? 1 : f < 4 ? 2 << (f - 1) : f < 10 ? (f % 2 ? 8 : 6) : 5 + (f - 10) % 3
      + ((f - 10) % 3 == 2 ? 1 : 0);
  endfunction
  function integer per(input integer f);
    per = f == 0 ? 1 : f < 4 ? 4 : f < 10 ? 4 << ((f - 4) >> 1) : f < 13 ? 32 : 64;
  endfunction
  // latency from pin change to filtered level, bounded wait
  task settle(input [4:0] v, input integer f);
    lvl <= v;
    t = 0;
    while (filtered_o[0] !== v[1] && t < 700) @(negedge clk_i) t = t + 1;
    chk(t >= (nsamp(f) - 1) * per(f) + 2 && t <= nsamp(f) * per(f) + 5, 1);
    @(posedge clk_i);
  endtask
  task results;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_i);
    for (c = 1; c < 5; c = c + 1) rd(8'(8'h20 + 4 * c), 32'h0000_0000);
    for (i = 0; i < 12; i = i + 1) begin
      d = $random(seed);
      wr(8'(8'h24 + 4 * (i % 3)), d);
      rd(8'(8'h24 + 4 * (i % 3)), d & `TCIC_CFG_WMASK);
    end
    cfg(1, 32'h0001_0000);
    @(posedge clk_i);
    for (i = 0; i < 4; i = i + 1) begin
      d = $random(seed);
      wr(`TCIC_OFS_CH1, d);
      rd(`TCIC_OFS_CH1, d & 32'h000c_000f | 32'h0001_0000);
    end
    $display("register test done");
    for (c = 1; c < 4; c = c + 1)
      for (s = 0; s < 4; s = s + 1) begin
        cfg(c, s << 16);
        toggle(src(c, s), 5);
        chk(ev, s ? 5 : 0);
      end
    c = 2;
    for (s = 0; s < 4; s = s + 1) begin
      cfg(2, 32'h0001_0000 | s << 18);
      toggle(5'h04, 16);
      chk(ev, 16 >> s);
    end
    cfg(2, 32'h0009_0000);
    toggle(5'h04, 3);
    cfg(2, 32'h0009_0000);
    toggle(5'h04, 3);
    chk(ev, 0);
    $display("routing and prescaler test done");
    c = 1;
    for (s = 0; s < 16; s = s + 1) begin
      cfg(1, 32'h0001_0000 | s);
      settle(5'h02, s);
      settle(5'h00, s);
    end
    $display("filter test done");
    results;
  end
  // cut a hang short well past the expected run
  initial begin
    #4_000_000;
    error_cnt = error_cnt + 1;
    results;
  end
endmodule // tcic_input_cond_tb_top
